// ==== hw/lrs_pkg.sv ====
/*
 * Shared constants for the light and reflection sensor control block:
 * timing figures, register offsets, field positions, reset values and enums.
 * Assumes a 100 MHz system clock; all counts derive from it.
 */
package lrs_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int US_PER_MS = 1000;
    localparam int LIGHT_CONV_MS = 100;
    localparam int REFL_CONV_US = 540;
    localparam int LED_PULSE_US = 100;
    localparam int SLEEP_MAX_MS = 800;
    localparam int LIGHT_CONV_CYC = LIGHT_CONV_MS * US_PER_MS * CYC_PER_US;
    localparam int REFL_CONV_CYC = REFL_CONV_US * CYC_PER_US;
    localparam int LED_PULSE_CYC = LED_PULSE_US * CYC_PER_US;
    localparam int SLEEP_MAX_CYC = SLEEP_MAX_MS * US_PER_MS * CYC_PER_US;
    localparam int SLEEP_SEL_MAX = 3;

    // ----------------------------------------------------------------
    // data widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int LIGHT_W = 12;
    localparam int REFL_W = 8;
    localparam int PERSIST_CNT_W = 5;
    localparam logic [LIGHT_W-1:0] LIGHT_FULL_SCALE = 12'hfff;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_PERSIST = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_LIGHT_LO = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_LIGHT_HI = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_REFL_THR = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_LIGHT_DATA = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_REFL_DATA = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG_W = 6;
    localparam int CFG_LIGHT_EN = 0;
    localparam int CFG_RANGE = 1;
    localparam int CFG_REFL_EN = 2;
    localparam int CFG_LED_HI = 3;
    localparam int CFG_SLEEP_LSB = 4;
    localparam int PERS_W = 4;
    localparam int PERS_LIGHT_LSB = 0;
    localparam int PERS_REFL_LSB = 2;
    localparam int STAT_LIGHT = 0;
    localparam int STAT_REFL = 1;
    localparam int STAT_PWRDN = 2;
    localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
    localparam logic [PERS_W-1:0] PERS_RESET = 4'h0;
    localparam logic [LIGHT_W-1:0] LIGHT_LO_RESET = 12'h000;
    localparam logic [REFL_W-1:0] REFL_THR_RESET = 8'hff;

    // ----------------------------------------------------------------
    // enums
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PERSIST_1 = 2'h0,
        PERSIST_4 = 2'h1,
        PERSIST_8 = 2'h2,
        PERSIST_16 = 2'h3
    } lrs_persist_t;

    typedef enum logic [1:0] {
        REFL_IDLE = 2'h0,
        REFL_CONV = 2'h1,
        REFL_SLEEP = 2'h3
    } lrs_refl_state_t;

    // consecutive triggers needed for a persistence setting
    function automatic logic [PERSIST_CNT_W-1:0] persist_need(input logic [1:0] sel);
        case (lrs_persist_t'(sel))
            PERSIST_1: persist_need = 5'h01;
            PERSIST_4: persist_need = 5'h04;
            PERSIST_8: persist_need = 5'h08;
            default: persist_need = 5'h10;
        endcase
    endfunction

endpackage

// ==== hw/lrs_persist.sv ====
/*
 * Persistence filter: counts consecutive triggering measurements and
 * pulses fire_o once the selected number is reached.
 * Assumes sample_valid_i is a one-cycle pulse per finished measurement.
 */
`timescale 1ns/1ps
`default_nettype none

module lrs_persist (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic sample_valid_i,
    input wire logic trigger_i,
    input wire logic [1:0] persist_sel_i,
    output logic fire_o
);

    typedef struct packed {
        logic [lrs_pkg::PERSIST_CNT_W-1:0] cnt;
        logic fire;
    } lrs_persist_state_t;

    lrs_persist_state_t st;
    lrs_persist_state_t next_st;
    logic [lrs_pkg::PERSIST_CNT_W-1:0] need;

    always_comb begin
        next_st = st;
        next_st.fire = 1'b0;
        need = lrs_pkg::persist_need(persist_sel_i);
        if (clear_i) begin
            next_st.cnt = '0;
        end else if (sample_valid_i) begin
            if (!trigger_i) begin
                next_st.cnt = '0;
            end else if (st.cnt + 5'h01 >= need) begin
                next_st.cnt = need;
                next_st.fire = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fire_o = st.fire;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_miss_resets_count: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sample_valid_i && !trigger_i |=> st.cnt == '0 && !fire_o)
        else $error("miss did not reset persistence count");

    a_fire_needs_run: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        fire_o |-> $past(sample_valid_i) && $past(trigger_i)
            && st.cnt == lrs_pkg::persist_need($past(persist_sel_i)))
        else $error("fire without enough consecutive triggers");

endmodule

`default_nettype wire

// ==== hw/lrs_refl_seq.sv ====
/*
 * Reflection channel sequencer: LED pulse inside each conversion,
 * then a selectable sleep before the next one.
 * Assumes enable_i and sleep_sel_i come from registers.
 */
`timescale 1ns/1ps
`default_nettype none

module lrs_refl_seq #(
    parameter int CONV_CYC = lrs_pkg::REFL_CONV_CYC,
    parameter int PULSE_CYC = lrs_pkg::LED_PULSE_CYC,
    parameter int SLEEP_MAX_CYC = lrs_pkg::SLEEP_MAX_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic [1:0] sleep_sel_i,
    output logic led_on_o,
    output logic conv_done_o
);

    localparam int CNT_W = $clog2(SLEEP_MAX_CYC + 1);

    if (PULSE_CYC < 1 || PULSE_CYC >= CONV_CYC || CONV_CYC > SLEEP_MAX_CYC) begin : g_bad_params
        $error("lrs_refl_seq: timing parameters out of range");
    end

    typedef struct packed {
        lrs_pkg::lrs_refl_state_t state;
        logic [CNT_W-1:0] cnt;
        logic led;
        logic done;
    } lrs_refl_seq_state_t;

    lrs_refl_seq_state_t st;
    lrs_refl_seq_state_t next_st;
    logic [CNT_W-1:0] sleep_len;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        sleep_len = CNT_W'(SLEEP_MAX_CYC) >> (2'(lrs_pkg::SLEEP_SEL_MAX) - sleep_sel_i);
        case (st.state)
            lrs_pkg::REFL_IDLE: begin
                if (enable_i) begin
                    next_st.state = lrs_pkg::REFL_CONV;
                    next_st.cnt = '0;
                    next_st.led = 1'b1;
                end
            end
            lrs_pkg::REFL_CONV: begin
                if (!enable_i) begin
                    next_st.state = lrs_pkg::REFL_IDLE;
                    next_st.led = 1'b0;
                end else if (st.cnt == CNT_W'(CONV_CYC - 1)) begin
                    next_st.state = lrs_pkg::REFL_SLEEP;
                    next_st.cnt = '0;
                    next_st.led = 1'b0;
                    next_st.done = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                    next_st.led = (st.cnt + 1'b1) < CNT_W'(PULSE_CYC);
                end
            end
            lrs_pkg::REFL_SLEEP: begin
                if (!enable_i) begin
                    next_st.state = lrs_pkg::REFL_IDLE;
                end else if (st.cnt >= sleep_len - 1'b1) begin
                    next_st.state = lrs_pkg::REFL_CONV;
                    next_st.cnt = '0;
                    next_st.led = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                end
            end
            default: begin
                next_st.state = lrs_pkg::REFL_IDLE;
                next_st.led = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign led_on_o = st.led;
    assign conv_done_o = st.done;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_led_pulse_width: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(st.led) && st.state == lrs_pkg::REFL_CONV |-> st.cnt == CNT_W'(PULSE_CYC))
        else $error("led pulse width wrong");

    a_conv_length: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.done |-> $past(st.cnt) == CNT_W'(CONV_CYC - 1) && !st.led)
        else $error("reflection conversion length wrong");

    a_sleep_bound: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.state == lrs_pkg::REFL_SLEEP |-> st.cnt < CNT_W'(SLEEP_MAX_CYC))
        else $error("sleep longer than maximum");

endmodule

`default_nettype wire

// ==== hw/lrs_top.sv ====
/*
 * Light and reflection sensor control: register file, light channel
 * timing and window test, reflection threshold test, persistence filters,
 * sticky status flags and the open-drain alert pin.
 * Assumes converter codes arrive synchronous to sys_clk_i and are valid
 * whenever a conversion ends; the board pulls the alert line up.
 */
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module lrs_top #(
    parameter int LIGHT_CONV_CYC = lrs_pkg::LIGHT_CONV_CYC,
    parameter int REFL_CONV_CYC = lrs_pkg::REFL_CONV_CYC,
    parameter int LED_PULSE_CYC = lrs_pkg::LED_PULSE_CYC,
    parameter int SLEEP_MAX_CYC = lrs_pkg::SLEEP_MAX_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [lrs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [lrs_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [lrs_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic [lrs_pkg::LIGHT_W-1:0] light_code_i,
    input wire logic [lrs_pkg::REFL_W-1:0] refl_code_i,
    output logic led_drive_pin_o,
    output logic led_current_high_o,
    output logic light_range_select_o,
    output logic alert_oe_o
);

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    if (LED_PULSE_CYC < 1 || LED_PULSE_CYC >= REFL_CONV_CYC
        || LIGHT_CONV_CYC < 2 || SLEEP_MAX_CYC < 8
        || REFL_CONV_CYC > SLEEP_MAX_CYC) begin : g_bad_timing
        $error("lrs_top: timing parameters out of range");
    end

    localparam int LCNT_W = $clog2(LIGHT_CONV_CYC);

    typedef struct packed {
        logic [lrs_pkg::CFG_W-1:0] cfg;
        logic [lrs_pkg::PERS_W-1:0] pers;
        logic [lrs_pkg::LIGHT_W-1:0] light_lo;
        logic [lrs_pkg::LIGHT_W-1:0] light_hi;
        logic [lrs_pkg::REFL_W-1:0] refl_thr;
        logic [lrs_pkg::LIGHT_W-1:0] light_data;
        logic [lrs_pkg::REFL_W-1:0] refl_data;
        logic [LCNT_W-1:0] light_cnt;
        logic light_done;
        logic light_trig;
        logic refl_done;
        logic refl_trig;
        logic light_flag;
        logic refl_flag;
        logic [lrs_pkg::DATA_W-1:0] rdata;
        logic led_hi;
        logic range;
        logic alert_oe;
    } lrs_top_state_t;

    lrs_top_state_t st;
    lrs_top_state_t next_st;
    logic light_en;
    logic refl_en;
    logic pwr_down;
    logic light_fire;
    logic refl_fire;
    logic refl_conv_done;
    logic [lrs_pkg::DATA_W-1:0] status_word;

    assign light_en = st.cfg[lrs_pkg::CFG_LIGHT_EN];
    assign refl_en = st.cfg[lrs_pkg::CFG_REFL_EN];
    assign pwr_down = !light_en && !refl_en;
    assign status_word = {13'h0, pwr_down, st.refl_flag, st.light_flag};

    // ----------------------------------------------------------------
    // reflection sequencer and persistence filters
    // ----------------------------------------------------------------
    lrs_refl_seq #(
        .CONV_CYC(REFL_CONV_CYC),
        .PULSE_CYC(LED_PULSE_CYC),
        .SLEEP_MAX_CYC(SLEEP_MAX_CYC)
    ) u_refl_seq (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(refl_en),
        .sleep_sel_i(st.cfg[lrs_pkg::CFG_SLEEP_LSB +: 2]),
        .led_on_o(led_drive_pin_o),
        .conv_done_o(refl_conv_done)
    );

    lrs_persist u_light_persist (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(!light_en),
        .sample_valid_i(st.light_done),
        .trigger_i(st.light_trig),
        .persist_sel_i(st.pers[lrs_pkg::PERS_LIGHT_LSB +: 2]),
        .fire_o(light_fire)
    );

    lrs_persist u_refl_persist (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(!refl_en),
        .sample_valid_i(st.refl_done),
        .trigger_i(st.refl_trig),
        .persist_sel_i(st.pers[lrs_pkg::PERS_REFL_LSB +: 2]),
        .fire_o(refl_fire)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.light_done = 1'b0;
        next_st.refl_done = 1'b0;
        next_st.rdata = '0;

        // light channel conversion timing
        if (!light_en) begin
            next_st.light_cnt = '0;
        end else if (st.light_cnt == LCNT_W'(LIGHT_CONV_CYC - 1)) begin
            next_st.light_cnt = '0;
            next_st.light_done = 1'b1;
            next_st.light_data = light_code_i;
            next_st.light_trig = (light_code_i < st.light_lo)
                || (light_code_i > st.light_hi);
        end else begin
            next_st.light_cnt = st.light_cnt + 1'b1;
        end

        // reflection result and threshold test
        if (refl_conv_done) begin
            next_st.refl_done = 1'b1;
            next_st.refl_data = refl_code_i;
            next_st.refl_trig = refl_code_i > st.refl_thr;
        end

        // register writes
        if (reg_wr_i) begin
            if (reg_addr_i == lrs_pkg::ADDR_CONFIG) begin
                next_st.cfg = reg_wdata_i[lrs_pkg::CFG_W-1:0];
            end else if (reg_addr_i == lrs_pkg::ADDR_PERSIST) begin
                next_st.pers = reg_wdata_i[lrs_pkg::PERS_W-1:0];
            end else if (reg_addr_i == lrs_pkg::ADDR_LIGHT_LO) begin
                next_st.light_lo = reg_wdata_i[lrs_pkg::LIGHT_W-1:0];
            end else if (reg_addr_i == lrs_pkg::ADDR_LIGHT_HI) begin
                next_st.light_hi = reg_wdata_i[lrs_pkg::LIGHT_W-1:0];
            end else if (reg_addr_i == lrs_pkg::ADDR_REFL_THR) begin
                next_st.refl_thr = reg_wdata_i[lrs_pkg::REFL_W-1:0];
            end
        end

        // sticky flags: write one clears, a new event wins
        next_st.light_flag = st.light_flag;
        next_st.refl_flag = st.refl_flag;
        if (reg_wr_i && reg_addr_i == lrs_pkg::ADDR_STATUS) begin
            if (reg_wdata_i[lrs_pkg::STAT_LIGHT]) begin
                next_st.light_flag = 1'b0;
            end
            if (reg_wdata_i[lrs_pkg::STAT_REFL]) begin
                next_st.refl_flag = 1'b0;
            end
        end
        if (light_fire) begin
            next_st.light_flag = 1'b1;
        end
        if (refl_fire) begin
            next_st.refl_flag = 1'b1;
        end
        next_st.alert_oe = next_st.light_flag || next_st.refl_flag;

        next_st.led_hi = next_st.cfg[lrs_pkg::CFG_LED_HI];
        next_st.range = next_st.cfg[lrs_pkg::CFG_RANGE];

        // register reads, data in the following cycle
        if (reg_rd_i) begin
            if (reg_addr_i == lrs_pkg::ADDR_CONFIG) begin
                next_st.rdata = {10'h000, st.cfg};
            end else if (reg_addr_i == lrs_pkg::ADDR_PERSIST) begin
                next_st.rdata = {12'h000, st.pers};
            end else if (reg_addr_i == lrs_pkg::ADDR_LIGHT_LO) begin
                next_st.rdata = {4'h0, st.light_lo};
            end else if (reg_addr_i == lrs_pkg::ADDR_LIGHT_HI) begin
                next_st.rdata = {4'h0, st.light_hi};
            end else if (reg_addr_i == lrs_pkg::ADDR_REFL_THR) begin
                next_st.rdata = {8'h00, st.refl_thr};
            end else if (reg_addr_i == lrs_pkg::ADDR_LIGHT_DATA) begin
                next_st.rdata = {4'h0, st.light_data};
            end else if (reg_addr_i == lrs_pkg::ADDR_REFL_DATA) begin
                next_st.rdata = {8'h00, st.refl_data};
            end else if (reg_addr_i == lrs_pkg::ADDR_STATUS) begin
                next_st.rdata = status_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.cfg <= lrs_pkg::CFG_RESET;
            st.pers <= lrs_pkg::PERS_RESET;
            st.light_lo <= lrs_pkg::LIGHT_LO_RESET;
            st.light_hi <= lrs_pkg::LIGHT_FULL_SCALE;
            st.refl_thr <= lrs_pkg::REFL_THR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_o = st.rdata;
    assign led_current_high_o = st.led_hi;
    assign light_range_select_o = st.range;
    assign alert_oe_o = st.alert_oe;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_light_sample;
        st.light_done ##1 !st.light_done;
    endsequence

    a_light_period: assert property (
        st.light_done |-> $past(st.light_cnt) == LCNT_W'(LIGHT_CONV_CYC - 1))
        else $error("light conversion period wrong");

    a_light_window: assert property (
        s_light_sample |-> $past(st.light_trig, 1)
            == (($past(st.light_data, 1) < $past(st.light_lo, 2))
            || ($past(st.light_data, 1) > $past(st.light_hi, 2))))
        else $error("light window test wrong");

    a_refl_threshold: assert property (
        st.refl_done |-> st.refl_trig == (st.refl_data > $past(st.refl_thr)))
        else $error("reflection threshold test wrong");

    a_alert_on_event: assert property (
        refl_fire || light_fire |=> alert_oe_o && (st.light_flag || st.refl_flag))
        else $error("event not shown on alert and status");

    a_clear_releases: assert property (
        reg_wr_i && reg_addr_i == lrs_pkg::ADDR_STATUS && reg_wdata_i[1:0] == 2'h3
            && !light_fire && !refl_fire |=> !alert_oe_o)
        else $error("clearing flags did not release alert");

    a_alert_holds: assert property (
        alert_oe_o && !(reg_wr_i && reg_addr_i == lrs_pkg::ADDR_STATUS) |=> alert_oe_o)
        else $error("alert dropped without clear");

    a_powered_down_quiet: assert property (
        pwr_down ##1 pwr_down |-> !led_drive_pin_o && st.light_cnt == '0)
        else $error("conversion running while powered down");

    a_light_off_clears: assert property (
        !light_en |=> st.light_cnt == '0)
        else $error("light counter kept running while disabled");

    a_rdata_one_cycle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data stood longer than one cycle");

    a_refl_capture: assert property (
        refl_conv_done |=> st.refl_data == $past(refl_code_i))
        else $error("reflection code not captured at conversion end");

    sequence s_light_event;
        st.light_done && st.light_trig && light_en
            && st.pers[lrs_pkg::PERS_LIGHT_LSB +: 2] == lrs_pkg::PERSIST_1;
    endsequence

    a_light_event_alert: assert property (
        s_light_event |-> ##2 alert_oe_o)
        else $error("light event did not reach the alert pin");

endmodule

`default_nettype wire

// ==== tb/lrs_led_model.sv ====
/*
 * led model: counts pulses on the drive pin and keeps the last width.
 * assumes an active-high drive level synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module lrs_led_model (
    input wire logic sys_clk_i,
    input wire logic led_on_i,
    output logic [7:0] pulses_o,
    output logic [7:0] width_o
);
    logic [7:0] run = 8'h00;
    logic [7:0] pulse_cnt = 8'h00;
    logic [7:0] last_width = 8'h00;
    assign pulses_o = pulse_cnt;
    assign width_o = last_width;
    always @(posedge sys_clk_i) begin
        if (led_on_i) begin
            run <= run + 8'h01;
        end else if (run != 8'h00) begin
            pulse_cnt <= pulse_cnt + 8'h01;
            last_width <= run;
            run <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// ==== tb/lrs_top_tb.sv ====
/*
 * self-checking bench for lrs_top with shortened conversion counts.
 * assumes the led model in lrs_led_model.sv.
 */
`timescale 1ns/1ps
`default_nettype none
module lrs_top_tb;
    typedef struct {logic [3:0] a; logic w; logic [15:0] d; logic [15:0] e;} lrs_row_t;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [11:0] light_code = 12'h000;
    logic [7:0] refl_code = 8'h00;
    logic led, led_hi, range_sel, alert;
    logic [7:0] pulses, width;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    lrs_row_t rows [0:9] = '{'{4'h0, 1'b0, 16'h0, 16'h0000}, '{4'h1, 1'b0, 16'h0, 16'h0000},
        '{4'h2, 1'b0, 16'h0, 16'h0000}, '{4'h3, 1'b0, 16'h0, 16'h0fff},
        '{4'h4, 1'b0, 16'h0, 16'h00ff}, '{4'h7, 1'b0, 16'h0, 16'h0004},
        '{4'h8, 1'b1, 16'hffff, 16'h0000}, '{4'h2, 1'b1, 16'h0123, 16'h0123},
        '{4'h1, 1'b1, 16'h000f, 16'h000f}, '{4'h5, 1'b1, 16'hffff, 16'h0000}};

    lrs_top #(.LIGHT_CONV_CYC(40), .REFL_CONV_CYC(20), .LED_PULSE_CYC(5), .SLEEP_MAX_CYC(32))
    i_lrs_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .light_code_i(light_code), .refl_code_i(refl_code), .led_drive_pin_o(led),
        .led_current_high_o(led_hi), .light_range_select_o(range_sel), .alert_oe_o(alert));
    lrs_led_model i_lrs_led_model (.sys_clk_i(sys_clk_i), .led_on_i(led),
        .pulses_o(pulses), .width_o(width));

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic conclude();
        $display("tests %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge sys_clk_i);
    endtask

    task automatic wait_hi(input int n);
        while (alert !== 1'b1 && n > 0) begin
            @(posedge sys_clk_i);
            #1 n--;
        end
        @(posedge sys_clk_i);
    endtask

    initial begin
        int base;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        foreach (rows[i]) begin
            if (rows[i].w) wr_reg(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("register rows done");
        light_code <= 12'h180;
        wr_reg(4'h1, 16'h0000);
        wr_reg(4'h2, 16'h0100);
        wr_reg(4'h3, 16'h0200);
        wr_reg(4'h0, 16'h0003);
        repeat (45) @(posedge sys_clk_i);
        chk({15'h0, alert}, 16'h0000);
        light_code <= 12'h050;
        wait_hi(60);
        chk({15'h0, alert}, 16'h0001);
        chk({15'h0, range_sel}, 16'h0001);
        rd_chk(4'h7, 16'h0001);
        rd_chk(4'h5, 16'h0050);
        wr_reg(4'h0, 16'h0000);
        wr_reg(4'h7, 16'h0001);
        rd_chk(4'h7, 16'h0004);
        chk({15'h0, alert}, 16'h0000);
        $display("light window test done");
        light_code <= 12'h180;
        refl_code <= 8'h20;
        wr_reg(4'h4, 16'h0010);
        wr_reg(4'h1, 16'h0004);
        base = pulses;
        wr_reg(4'h0, 16'h003d);
        wait_hi(400);
        chk(16'(pulses - base[7:0]), 16'h0004);
        chk({8'h0, width}, 16'h0005);
        chk({15'h0, led_hi}, 16'h0001);
        chk({15'h0, range_sel}, 16'h0000);
        rd_chk(4'h7, 16'h0002);
        rd_chk(4'h5, 16'h0180);
        rd_chk(4'h6, 16'h0020);
        wr_reg(4'h0, 16'h0000);
        repeat (25) @(posedge sys_clk_i);
        chk({15'h0, led}, 16'h0000);
        chk({15'h0, alert}, 16'h0001);
        $display("reflection persistence test done");
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chk({15'h0, alert}, 16'h0000);
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'h7, 16'h0004);
        $display("reset test done");
        conclude();
    end
endmodule
`default_nettype wire
